// ### src/rssd_datapath.sv
`timescale 1ns/1ps
`include "rssd_defines.svh"
module rssd_datapath
(
    input  wire logic                 clk,       // core instruction clock
    input  wire logic                 sys_rst,   // synchronous reset, active high
    input  wire logic                 clkEn,     // freezes all state while low
    input  wire rssd_pkg::rssd_instr_t instr,    // decoded instruction and operands
    input  wire logic [5:0]           flagsIn,   // flag load value
    input  wire logic                 flagsLoad, // load flags from flagsIn
    output logic [7:0]                acc,       // accumulator
    output logic [5:0]                flags,     // status flags
    output rssd_pkg::rssd_result_t    result,    // memory write, skip, done
    output logic                      busy       // dummy cycle in progress
);
    import rssd_pkg::*;

    rssd_regs_t cur;
    rssd_regs_t nxt;

    logic [7:0] opnd;
    logic [8:0] diff;
    logic [4:0] lowDiff;
    logic       borrowIn;
    logic       isSub;
    logic       isSubB;
    logic       oldC;
    logic [7:0] dec8;
    logic [7:0] inc8;

    always_comb
    begin
        opnd     = instr.useImm ? instr.immData : instr.memData;
        oldC     = cur.flags[`RSSD_FLAG_C];
        isSubB   = (instr.op == RSSD_OP_SUBB) || (instr.op == RSSD_OP_SUBB_M);
        isSub    = isSubB || (instr.op == RSSD_OP_SUB) || (instr.op == RSSD_OP_SUB_M);
        borrowIn = isSubB ? ~oldC : 1'b0;
        diff     = {1'b0, cur.acc} - {1'b0, opnd} - {8'h00, borrowIn};
        lowDiff  = {1'b0, cur.acc[3:0]} - {1'b0, opnd[3:0]} - {4'h0, borrowIn};
        dec8     = instr.memData - 8'h01;
        inc8     = instr.memData + 8'h01;
    end

    always_comb
    begin
        nxt          = cur;
        nxt.res      = '0;
        if (cur.state == RSSD_ST_DUMMY)
        begin
            nxt.state    = RSSD_ST_EXEC;
            nxt.res.done = 1'b1;
        end
        else if (instr.valid)
        begin
            unique case (instr.op)
                RSSD_OP_RLA:
                    nxt.acc = {instr.memData[6:0], instr.memData[7]};
                RSSD_OP_RLC:
                begin
                    nxt.res.memWe    = 1'b1;
                    nxt.res.memWdata = {instr.memData[6:0], oldC};
                    nxt.flags[`RSSD_FLAG_C] = instr.memData[7];
                end
                RSSD_OP_ROTATE_LEFT_CARRY_TO_ACCUMULATOR:
                begin
                    nxt.acc = {instr.memData[6:0], oldC};
                    nxt.flags[`RSSD_FLAG_C] = instr.memData[7];
                end
                RSSD_OP_RR:
                begin
                    nxt.res.memWe    = 1'b1;
                    nxt.res.memWdata = {instr.memData[0], instr.memData[7:1]};
                end
                RSSD_OP_RRA:
                    nxt.acc = {instr.memData[0], instr.memData[7:1]};
                RSSD_OP_RRC:
                begin
                    nxt.res.memWe    = 1'b1;
                    nxt.res.memWdata = {oldC, instr.memData[7:1]};
                    nxt.flags[`RSSD_FLAG_C] = instr.memData[0];
                end
                RSSD_OP_ROTATE_RIGHT_CARRY_TO_ACCUMULATOR:
                begin
                    nxt.acc = {oldC, instr.memData[7:1]};
                    nxt.flags[`RSSD_FLAG_C] = instr.memData[0];
                end
                RSSD_OP_SUBB, RSSD_OP_SUB:
                    nxt.acc = diff[7:0];
                RSSD_OP_SUBB_M, RSSD_OP_SUB_M:
                begin
                    nxt.res.memWe    = 1'b1;
                    nxt.res.memWdata = diff[7:0];
                end
                RSSD_OP_DECSKZ:
                begin
                    nxt.res.memWe    = 1'b1;
                    nxt.res.memWdata = dec8;
                    nxt.res.skip     = (dec8 == 8'h00);
                end
                RSSD_OP_DECSKZ_A:
                begin
                    nxt.acc      = dec8;
                    nxt.res.skip = (dec8 == 8'h00);
                end
                RSSD_OP_INCSKZ:
                begin
                    nxt.res.memWe    = 1'b1;
                    nxt.res.memWdata = inc8;
                    nxt.res.skip     = (inc8 == 8'h00);
                end
                RSSD_OP_INCSKZ_A:
                begin
                    nxt.acc      = inc8;
                    nxt.res.skip = (inc8 == 8'h00);
                end
                RSSD_OP_SETB:
                begin
                    nxt.res.memWe    = 1'b1;
                    nxt.res.memWdata = `RSSD_ALL_ONES;
                end
                RSSD_OP_SETBIT:
                begin
                    nxt.res.memWe    = 1'b1;
                    nxt.res.memWdata = instr.memData | (8'h01 << instr.bitSel);
                end
                RSSD_OP_SKBIT:
                    nxt.res.skip = instr.memData[instr.bitSel];
                RSSD_OP_SKNZ:
                begin
                    nxt.res.memWe    = 1'b1;
                    nxt.res.memWdata = instr.memData;
                    nxt.res.skip     = (instr.memData != 8'h00);
                end
                default:
                    nxt.res.memWe = 1'b0;
            endcase
            if (isSub)
            begin
                nxt.flags[`RSSD_FLAG_C]  = ~diff[8];
                nxt.flags[`RSSD_FLAG_AC] = ~lowDiff[4];
                nxt.flags[`RSSD_FLAG_Z]  = (diff[7:0] == 8'h00);
                nxt.flags[`RSSD_FLAG_OV] = (cur.acc[7] ^ opnd[7]) & (cur.acc[7] ^ diff[7]);
                // signed carry is overflow folded with the sign of the difference
                nxt.flags[`RSSD_FLAG_SC] = nxt.flags[`RSSD_FLAG_OV] ^ diff[7];
                nxt.flags[`RSSD_FLAG_CZ] = isSubB
                    ? ((diff[7:0] == 8'h00) & cur.flags[`RSSD_FLAG_Z])
                    : (diff[7:0] == 8'h00);
            end
            if (instr.op inside {RSSD_OP_DECSKZ, RSSD_OP_DECSKZ_A, RSSD_OP_INCSKZ,
                                 RSSD_OP_INCSKZ_A, RSSD_OP_SKBIT, RSSD_OP_SKNZ})
                nxt.state = RSSD_ST_DUMMY;
            else
                nxt.res.done = 1'b1;
        end
        if (flagsLoad)
            nxt.flags = flagsIn;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            cur.state <= RSSD_ST_EXEC;
            cur.acc   <= `RSSD_ACC_RST;
            cur.flags <= `RSSD_FLAGS_RST;
            cur.res   <= '0;
        end
        else if (clkEn)
            cur <= nxt;
    end

    assign acc    = cur.acc;
    assign flags  = cur.flags;
    assign result = cur.res;
    assign busy   = (cur.state == RSSD_ST_DUMMY);
endmodule

// ### src/rssd_defines.svh
`ifndef RSSD_DEFINES_SVH
`define RSSD_DEFINES_SVH
`define RSSD_DATA_W       8
`define RSSD_ACC_RST      8'h00
`define RSSD_ALL_ONES     8'hFF
`define RSSD_FLAG_OV      0
`define RSSD_FLAG_Z       1
`define RSSD_FLAG_AC      2
`define RSSD_FLAG_C       3
`define RSSD_FLAG_SC      4
`define RSSD_FLAG_CZ      5
`define RSSD_FLAGS_W      6
`define RSSD_FLAGS_RST    6'h00
`define RSSD_DUMMY_CYCLES 1
`endif

// ### src/rssd_pkg.sv
package rssd_pkg;
    typedef enum logic [4:0] {
        RSSD_OP_NOP      = 5'h00,
        RSSD_OP_RLA      = 5'h01,
        RSSD_OP_RLC      = 5'h02,
        RSSD_OP_ROTATE_LEFT_CARRY_TO_ACCUMULATOR     = 5'h03,
        RSSD_OP_RR       = 5'h04,
        RSSD_OP_RRA      = 5'h05,
        RSSD_OP_RRC      = 5'h06,
        RSSD_OP_ROTATE_RIGHT_CARRY_TO_ACCUMULATOR     = 5'h07,
        RSSD_OP_SUBB     = 5'h08,
        RSSD_OP_SUBB_M   = 5'h09,
        RSSD_OP_SUB      = 5'h0A,
        RSSD_OP_SUB_M    = 5'h0B,
        RSSD_OP_DECSKZ   = 5'h0C,
        RSSD_OP_DECSKZ_A = 5'h0D,
        RSSD_OP_INCSKZ   = 5'h0E,
        RSSD_OP_INCSKZ_A = 5'h0F,
        RSSD_OP_SETB     = 5'h10,
        RSSD_OP_SETBIT   = 5'h11,
        RSSD_OP_SKBIT    = 5'h12,
        RSSD_OP_SKNZ     = 5'h13
    } rssd_op_t;

    typedef struct packed {
        logic       valid;
        rssd_op_t   op;
        logic       useImm;
        logic [2:0] bitSel;
        logic [7:0] memData;
        logic [7:0] immData;
    } rssd_instr_t;

    typedef struct packed {
        logic       memWe;
        logic [7:0] memWdata;
        logic       skip;
        logic       done;
    } rssd_result_t;

    typedef enum logic [0:0] {
        RSSD_ST_EXEC  = 1'b0,
        RSSD_ST_DUMMY = 1'b1
    } rssd_state_t;

    typedef struct packed {
        rssd_state_t  state;
        logic [7:0]   acc;
        logic [5:0]   flags;
        rssd_result_t res;
    } rssd_regs_t;
endpackage

// ### dv/rssd_checker.sv
`timescale 1ns/1ps
module rssd_checker
(
    input wire logic                   clk,       // clock
    input wire logic                   sys_rst,   // reset
    input wire logic                   clkEn,     // enable
    input wire rssd_pkg::rssd_instr_t  instr,     // request
    input wire logic [5:0]             flagsIn,   // flag value
    input wire logic                   flagsLoad, // flag load
    input wire logic [7:0]             acc,       // accumulator
    input wire logic [5:0]             flags,     // flags
    input wire rssd_pkg::rssd_result_t result,    // result
    input wire logic                   busy       // dummy cycle
);
    import rssd_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire       take = clkEn && instr.valid && !busy;
    wire [4:0] op   = instr.op;
    wire       isSk = op inside {5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h12, 5'h13};
    sequence s_take_skip;
        take && isSk ##1 clkEn;
    endsequence
    sequence s_dummy;
        busy && !result.done;
    endsequence
    a_skip_dummy: assert property (take && isSk |=> s_dummy)
        else $error("skip op gave no dummy cycle");
    a_skip_done: assert property (s_take_skip |=> result.done && !busy)
        else $error("skip op did not finish after dummy cycle");
    a_busy_ignore: assert property (busy && clkEn |=> !result.memWe && !busy)
        else $error("request taken during dummy cycle");
    a_dec_skip: assert property (take && op == 5'h0C |=> result.memWe
        && result.skip == ($past(instr.memData) == 8'h01))
        else $error("decrement skip wrong");
    a_inc_wrap: assert property (take && op == 5'h0E
        |=> result.memWdata == $past(instr.memData) + 8'h01)
        else $error("increment value wrong");
    a_set_byte: assert property (take && op == 5'h10
        |=> result.memWe && result.memWdata == 8'hFF)
        else $error("byte set wrong");
    a_rot_left: assert property (take && op == 5'h01 |=> !result.memWe
        && acc == {$past(instr.memData[6:0]), $past(instr.memData[7])})
        else $error("left rotate to accumulator wrong");
    a_flags_keep: assert property (take && !flagsLoad
        && op inside {5'h01, 5'h04, 5'h05, 5'h10, 5'h11, 5'h12, 5'h13} |=> $stable(flags))
        else $error("flags changed by flag-free op");
    a_sub_carry: assert property (take && op == 5'h0A && !instr.useImm && !flagsLoad
        |=> flags[3] == ($past(acc) >= $past(instr.memData)))
        else $error("subtract carry wrong");
    a_clken_freeze: assert property (!clkEn |=> $stable(acc) && $stable(flags)
        && $stable(result) && $stable(busy))
        else $error("state moved while clock enable low");
endmodule
bind rssd_datapath rssd_checker u_rssd_checker (.clk, .sys_rst, .clkEn, .instr, .flagsIn,
    .flagsLoad, .acc, .flags, .result, .busy);

// ### dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import rssd_pkg::*;
    logic         clk       = 0;
    logic         sys_rst   = 1;
    logic         clkEn     = 1;
    rssd_instr_t  instr     = '0;
    logic [5:0]   flagsIn   = '0;
    logic         flagsLoad = 0;
    logic [7:0]   acc;
    logic [5:0]   flags;
    rssd_result_t result;
    logic         busy;
    logic [7:0]   cWd;
    logic         cWe, cSk, cDn, cDn2, cWe2;
    int           n_errors  = 0;
    int           n_tests   = 0;
    int           cyc       = 0;
    always #2 clk = ~clk;
    rssd_datapath u_rssd_datapath (.clk, .sys_rst, .clkEn, .instr, .flagsIn, .flagsLoad,
        .acc, .flags, .result, .busy);
    task automatic report_and_stop;
        $display("errors %0d tests %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc > 3000)
        begin
            n_errors++;
            report_and_stop;
        end
    end
    task automatic chk(input logic [7:0] g, e);
        n_tests++;
        if (g !== e)
        begin
            n_errors++;
            $display("BAD %0t got %h expected %h", $time, g, e);
        end
    endtask
    // one op; during a dummy cycle a byte set is offered and must be ignored
    task automatic run(input logic [4:0] op, input logic [7:0] m, x, input logic u,
        input logic [2:0] b);
        @(posedge clk);
        #1;
        instr = '{1'b1, rssd_op_t'(op), u, b, m, x};
        @(posedge clk);
        #1;
        {cWe, cWd, cSk, cDn} = result;
        cDn2 = 0;
        cWe2 = 0;
        if (busy === 1'b1)
        begin
            instr.op = rssd_op_t'(5'h10);
            @(posedge clk);
            #1;
            cDn2 = result.done;
            cWe2 = result.memWe;
        end
        instr.valid = 0;
        chk(cDn | cDn2, 1);
    endtask
    // an offered op with the clock enable low must leave acc, result.done and busy unchanged
    task automatic frz(input logic [7:0] a0);
        @(posedge clk);
        #1;
        clkEn = 0;
        instr = '{1'b1, RSSD_OP_RLA, 1'b0, 3'h0, 8'h0F, 8'h00};
        repeat (2) @(posedge clk);
        #1;
        chk(acc, a0);
        chk(result.done, 0);
        chk(busy, 0);
        instr.valid = 0;
        clkEn = 1;
    endtask
    task automatic setf(input logic [5:0] f);
        @(posedge clk);
        #1;
        flagsIn = f;
        flagsLoad = 1;
        @(posedge clk);
        #1;
        flagsLoad = 0;
        chk(flags, f);
    endtask
    task automatic rot(input logic [4:0] op, input logic [7:0] m, e, input logic we, c);
        run(op, m, 8'h00, 0, 0);
        chk(cWe, we);
        chk(we ? cWd : acc, e);
        chk(flags[3], c);
    endtask
    task automatic sub(input logic [4:0] op, input logic [7:0] a, m, input logic u,
        input logic [5:0] f);
        logic       bop, bo, ov;
        logic [8:0] t;
        logic [4:0] h;
        bop = op inside {5'h08, 5'h09};
        bo = bop && !f[3];
        t = {1'b0, a} - {1'b0, m} - bo;
        h = {1'b0, a[3:0]} - {1'b0, m[3:0]} - bo;
        ov = (a[7] != m[7]) && (t[7] != a[7]);
        setf(f);
        run(5'h01, {a[0], a[7:1]}, 8'h00, 0, 0);
        run(op, u ? ~m : m, u ? m : ~m, u, 0);
        chk(flags, {t[7:0] == 0 && (!bop || f[1]), ov ^ t[7], !t[8], !h[4], t[7:0] == 0, ov});
        chk(op[0] ? cWd : acc, t[7:0]);
        chk(op[0] ? acc : cWe, op[0] ? a : 8'h00);
    endtask
    task automatic skp(input logic [4:0] op, input logic [7:0] m, input logic [2:0] b,
        input logic [7:0] e, input logic s);
        setf(6'h2A);
        run(op, m, 8'h00, 0, b);
        chk(cSk, s);
        chk({cDn, cDn2, cWe2}, 3'b010);
        chk(flags, 6'h2A);
        if (op != 5'h12) chk(cWe, !op[0] || op == 5'h13);
        if (op != 5'h12) chk(op[0] && op != 5'h13 ? acc : cWd, e);
    endtask
    task automatic setb(input logic [4:0] op, input logic [7:0] m, input logic [2:0] b,
        input logic [7:0] e);
        setf(6'h15);
        run(op, m, 8'h00, 0, b);
        chk(cWe, 1);
        chk(cWd, e);
        chk(flags, 6'h15);
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        #1;
        sys_rst = 0;
        chk(acc, 8'h00);
        chk(flags, 6'h00);
        chk(busy, 0);
        setf(6'h08);
        rot(5'h01, 8'h16, 8'h2C, 0, 1);
        rot(5'h02, 8'h16, 8'h2D, 1, 0);
        rot(5'h03, 8'h96, 8'h2C, 0, 1);
        rot(5'h04, 8'h16, 8'h0B, 1, 1);
        rot(5'h05, 8'h17, 8'h8B, 0, 1);
        rot(5'h06, 8'h16, 8'h8B, 1, 0);
        rot(5'h07, 8'h17, 8'h0B, 0, 1);
        frz(8'h0B);
        sub(5'h0A, 8'h05, 8'h03, 0, 6'h00);
        sub(5'h0A, 8'h80, 8'h01, 1, 6'h00);
        sub(5'h0B, 8'h03, 8'h05, 0, 6'h08);
        sub(5'h08, 8'h10, 8'h0F, 0, 6'h02);
        sub(5'h08, 8'h10, 8'h0F, 0, 6'h08);
        sub(5'h08, 8'h40, 8'hC0, 1, 6'h08);
        sub(5'h09, 8'h00, 8'h00, 0, 6'h00);
        skp(5'h0C, 8'h01, 0, 8'h00, 1);
        skp(5'h0C, 8'h05, 0, 8'h04, 0);
        skp(5'h0D, 8'h01, 0, 8'h00, 1);
        skp(5'h0E, 8'hFF, 0, 8'h00, 1);
        skp(5'h0F, 8'h7F, 0, 8'h80, 0);
        skp(5'h0F, 8'hFF, 0, 8'h00, 1);
        skp(5'h12, 8'h08, 3, 8'h00, 1);
        skp(5'h12, 8'hF7, 3, 8'h00, 0);
        skp(5'h13, 8'h5A, 0, 8'h5A, 1);
        skp(5'h13, 8'h00, 0, 8'h00, 0);
        setb(5'h10, 8'h12, 0, 8'hFF);
        setb(5'h11, 8'h12, 7, 8'h92);
        setb(5'h11, 8'h00, 4, 8'h10);
        report_and_stop;
    end
endmodule
